// >>> design/eprs_defs.svh
// eprs_defs.svh: timing, opcode and delivery-value constants for the power/reset sequencer
// assumes a 50 MHz system clock; included by the package and the design files
`ifndef EPRS_DEFS_SVH
`define EPRS_DEFS_SVH
`define EPRS_CLK_MHZ           50
`define EPRS_POWERUP_US        30
`define EPRS_SLEEP_ENTRY_US    10
`define EPRS_IDLE_RST_US       30
`define EPRS_MODIFY_RST_MS     12
`define EPRS_ERASE_RST_MS      25
`define EPRS_CMD_RESET_ARM     8'h66
`define EPRS_CMD_RESET         8'h99
`define EPRS_CMD_SLEEP_EXIT    8'hab
`define EPRS_CMD_SLEEP_ENTER   8'hb9
`define EPRS_ARRAY_ERASED      8'hff
`define EPRS_STATUS_DELIVERY   8'h00
`define EPRS_SAFETY_DELIVERY   8'h00
`define EPRS_CONFIG_DELIVERY   8'h20
`define EPRS_VOLATILE_DELIVERY 8'h01
`define EPRS_BITS_PER_CMD      4'h8
`define EPRS_EVT_LATENCY       5
`endif

// >>> design/eprs_pkg.sv
// eprs_pkg.sv: types shared by the power/reset sequencer files
// assumes eprs_defs.svh is on the include path
`include "eprs_defs.svh"
package eprs_pkg;
   typedef enum logic [2:0] {
      EPRS_POWERUP  = 3'b000,
      EPRS_STANDBY  = 3'b001,
      EPRS_ENTERING = 3'b010,
      EPRS_SLEEP    = 3'b011,
      EPRS_RESETTING = 3'b100
   } eprs_state_e;
   // one finished instruction, handed from the link clock domain
   typedef struct packed {
      logic [7:0] opcode;
      logic       exact8;
   } eprs_cmd_s;
   // delivery contents of the registers and erased array
   typedef struct packed {
      logic [7:0] status;
      logic [7:0] safety;
      logic [7:0] cfg;
      logic [7:0] volatile_r;
      logic [7:0] array_byte;
   } eprs_regs_s;
endpackage

// >>> design/eprs_spi_rx.sv
// eprs_spi_rx.sv: opcode shifter on the spi link clock, one instruction per select frame
// assumes sclk is generated by the host and may stop outside frames; cs_n is active low
`timescale 1ns/100ps
`include "eprs_defs.svh"
module eprs_spi_rx
   import eprs_pkg::*;
(
   input  wire logic       sclk,
   input  wire logic       cs_n,
   input  wire logic       mosi,
   output eprs_cmd_s       cmd,
   output logic            cmd_tgl
);
   logic [7:0] shift_r;
   logic [3:0] count_r;
   // no reset reaches the link side; a known start keeps the toggle from staying unknown
   logic       tgl_r = 1'b0;
   wire  [7:0] shift_nxt = {shift_r[6:0], mosi};
   wire  [3:0] count_nxt = (count_r == 4'hf) ? count_r : count_r + 4'h1;
   // count is cleared by the frame's own select, since no edge arrives after the frame
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         count_r <= 4'h0;
      end else begin
         count_r <= count_nxt;
      end
   end
   always_ff @(posedge sclk) begin
      shift_r <= shift_nxt;
   end
   // frame end: capture on the rising select, toggle hands the event over
   always_ff @(posedge cs_n) begin
      cmd.opcode <= shift_r;
      cmd.exact8 <= (count_r == `EPRS_BITS_PER_CMD);
      tgl_r      <= ~tgl_r;
   end
   assign cmd_tgl = tgl_r;
endmodule // eprs_spi_rx

// >>> design/eprs_power_reset.sv
// eprs_power_reset.sv: power-up, deep power-down and software reset sequencer
// assumes sys_clk at 50 MHz, spi link clock from the host, rst synchronous active high
// Functional notes
// - busy flag reads 1 from power-up until 30 us elapsed
// - deep power-down reached at most 10 us after select rises
// - reset with no modify in progress completes within 30 us
// - reset during modify other than chip erase completes within 12 ms
// - reset during chip erase completes within 25 ms
// - erased array bytes read ffh as delivered
// - status register delivered as 00h
// - safety register delivered as 00h
// - configuration register delivered as 20h
// - volatile register delivered as 01h
// - in power-down only release and reset instructions act
// - reset needs 66h then 99h directly; no command during recovery
// - release opcode abh, exactly eight bits then select high
// - entry opcode b9h, runs only on exactly eight bits
`timescale 1ns/100ps
`include "eprs_defs.svh"
module eprs_power_reset
   import eprs_pkg::*;
#(
   parameter int POWERUP_CYC = `EPRS_POWERUP_US * `EPRS_CLK_MHZ,
   parameter int ENTRY_CYC   = `EPRS_SLEEP_ENTRY_US * `EPRS_CLK_MHZ,
   parameter int IDLE_RST_CYC = `EPRS_IDLE_RST_US * `EPRS_CLK_MHZ,
   parameter int MODIFY_RST_CYC = `EPRS_MODIFY_RST_MS * 1000 * `EPRS_CLK_MHZ,
   parameter int ERASE_RST_CYC  = `EPRS_ERASE_RST_MS * 1000 * `EPRS_CLK_MHZ
)(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       spi_clk,
   input  wire logic       cs_n,
   input  wire logic       mosi,
   input  wire logic       modify_busy,
   input  wire logic       chip_erase_busy,
   output logic            write_in_progress_flag,
   output logic            deep_power_down,
   output logic            device_reset_pulse,
   output logic            cmd_accept_pulse,
   output logic [7:0]      accepted_opcode,
   output eprs_regs_s      delivery_regs
);
   eprs_cmd_s   link_cmd;
   logic        link_tgl;
   logic [2:0]  tgl_sync_r;
   eprs_cmd_s   cmd_r;
   eprs_state_e state_r;
   eprs_state_e state_nxt;
   logic [20:0] timer_r;
   logic [20:0] timer_nxt;
   logic        armed_r;
   logic        armed_nxt;

   eprs_spi_rx u_rx (
      .sclk    (spi_clk),
      .cs_n    (cs_n),
      .mosi    (mosi),
      .cmd     (link_cmd),
      .cmd_tgl (link_tgl)
   );

   // toggle synchroniser; the command word is stable long before the toggle is seen
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tgl_sync_r <= 3'h0;
      end else begin
         tgl_sync_r <= {tgl_sync_r[1:0], link_tgl};
      end
   end
   wire cmd_evt = tgl_sync_r[2] ^ tgl_sync_r[1];
   always_ff @(posedge sys_clk) begin
      if (cmd_evt) begin
         cmd_r <= link_cmd;
      end
   end
   logic evt_r;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         evt_r <= 1'b0;
      end else begin
         evt_r <= cmd_evt;
      end
   end

   wire       valid8    = evt_r && cmd_r.exact8;
   wire       is_arm    = valid8 && (cmd_r.opcode == `EPRS_CMD_RESET_ARM);
   wire       is_reset  = valid8 && (cmd_r.opcode == `EPRS_CMD_RESET) && armed_r;
   wire       is_enter  = valid8 && (cmd_r.opcode == `EPRS_CMD_SLEEP_ENTER);
   wire       is_exit   = valid8 && (cmd_r.opcode == `EPRS_CMD_SLEEP_EXIT);
   wire       timer_done = (timer_r == 21'h0);
   wire [20:0] rst_load = chip_erase_busy ? 21'(ERASE_RST_CYC - 1) :
                          modify_busy     ? 21'(MODIFY_RST_CYC - 1) :
                                            21'(IDLE_RST_CYC - 1);
   wire       busy_state = (state_r == EPRS_POWERUP) || (state_r == EPRS_RESETTING);

   always_comb begin
      state_nxt = state_r;
      timer_nxt = timer_done ? timer_r : timer_r - 21'h1;
      armed_nxt = armed_r;
      if (evt_r) begin
         armed_nxt = 1'b0;
      end
      unique case (state_r)
         EPRS_POWERUP: begin
            if (timer_done) begin
               state_nxt = EPRS_STANDBY;
            end
         end
         EPRS_STANDBY: begin
            if (is_reset) begin
               state_nxt = EPRS_RESETTING;
               timer_nxt = rst_load;
            end else if (is_enter) begin
               state_nxt = EPRS_ENTERING;
               // shortened by the decode latency, so the limit counts from select rising
               timer_nxt = 21'(ENTRY_CYC - 1 - `EPRS_EVT_LATENCY);
            end
            if (is_arm) begin
               armed_nxt = 1'b1;
            end
         end
         EPRS_ENTERING: begin
            if (is_reset) begin
               state_nxt = EPRS_RESETTING;
               timer_nxt = rst_load;
            end else if (timer_done) begin
               state_nxt = EPRS_SLEEP;
            end
            if (is_arm) begin
               armed_nxt = 1'b1;
            end
         end
         EPRS_SLEEP: begin
            // only release and reset instructions wake the sequencer
            if (is_reset) begin
               state_nxt = EPRS_RESETTING;
               timer_nxt = rst_load;
            end else if (is_exit) begin
               state_nxt = EPRS_STANDBY;
            end
            if (is_arm) begin
               armed_nxt = 1'b1;
            end
         end
         EPRS_RESETTING: begin
            armed_nxt = 1'b0;
            if (timer_done) begin
               state_nxt = EPRS_STANDBY;
            end
         end
         default: begin
            state_nxt = EPRS_POWERUP;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_r <= EPRS_POWERUP;
         timer_r <= 21'(POWERUP_CYC - 1);
         armed_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         timer_r <= timer_nxt;
         armed_r <= armed_nxt;
      end
   end

   wire accept = evt_r && cmd_r.exact8 && !busy_state &&
                 (state_r != EPRS_SLEEP || is_exit || is_arm || is_reset);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         write_in_progress_flag <= 1'b1;
         deep_power_down        <= 1'b0;
         device_reset_pulse     <= 1'b0;
         cmd_accept_pulse       <= 1'b0;
         accepted_opcode        <= 8'h00;
      end else begin
         write_in_progress_flag <= (state_nxt == EPRS_POWERUP) ||
                                   (state_nxt == EPRS_RESETTING);
         deep_power_down        <= (state_nxt == EPRS_SLEEP);
         device_reset_pulse     <= (state_r == EPRS_RESETTING) && timer_done;
         cmd_accept_pulse       <= accept;
         accepted_opcode        <= accept ? cmd_r.opcode : accepted_opcode;
      end
   end

   // delivery values: loaded at reset, never changed by this block
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         delivery_regs.status     <= `EPRS_STATUS_DELIVERY;
         delivery_regs.safety     <= `EPRS_SAFETY_DELIVERY;
         delivery_regs.cfg        <= `EPRS_CONFIG_DELIVERY;
         delivery_regs.volatile_r <= `EPRS_VOLATILE_DELIVERY;
         delivery_regs.array_byte <= `EPRS_ARRAY_ERASED;
      end
   end

   // assertions
   property p_wip_powerup;
      @(posedge sys_clk) disable iff (rst)
      (state_r == EPRS_POWERUP) |=> write_in_progress_flag || state_r == EPRS_STANDBY;
   endproperty
   a_wip_powerup: assert property (p_wip_powerup) else $error("busy low in power-up");
   property p_enter_sleep;
      @(posedge sys_clk) disable iff (rst)
      (state_r == EPRS_STANDBY && is_enter && !is_reset) |=> ##[1:500] deep_power_down;
   endproperty
   a_enter_sleep: assert property (p_enter_sleep) else $error("sleep late");
   // recovery age counted in helper logic; a delay range this long is too heavy for the tools
   logic [20:0] rec_age_r;
   logic        rec_idle_r;
   always_ff @(posedge sys_clk) begin
      if (rst || state_r != EPRS_RESETTING) begin
         rec_age_r <= 21'h0;
      end else begin
         rec_age_r <= rec_age_r + 21'h1;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rec_idle_r <= 1'b0;
      end else if (state_r != EPRS_RESETTING) begin
         rec_idle_r <= !modify_busy && !chip_erase_busy;
      end
   end
   property p_idle_rst;
      @(posedge sys_clk) disable iff (rst)
      (state_r == EPRS_RESETTING && rec_idle_r) |-> rec_age_r < 21'(IDLE_RST_CYC);
   endproperty
   a_idle_rst: assert property (p_idle_rst) else $error("idle reset late");
   property p_sleep_ignore;
      @(posedge sys_clk) disable iff (rst)
      (state_r == EPRS_SLEEP && evt_r && !is_exit && !is_reset) |=> state_r == EPRS_SLEEP;
   endproperty
   a_sleep_ignore: assert property (p_sleep_ignore) else $error("sleep left");
   property p_arm_needed;
      @(posedge sys_clk) disable iff (rst)
      (evt_r && !armed_r) |=> state_r != EPRS_RESETTING || $past(state_r) == EPRS_RESETTING;
   endproperty
   a_arm_needed: assert property (p_arm_needed) else $error("reset unarmed");
   property p_cfg;
      @(posedge sys_clk) disable iff (rst)
      1 |-> delivery_regs.cfg == `EPRS_CONFIG_DELIVERY &&
            delivery_regs.volatile_r == `EPRS_VOLATILE_DELIVERY;
   endproperty
   a_cfg: assert property (p_cfg) else $error("delivery regs changed");
   c_sleep: cover property (@(posedge sys_clk) deep_power_down);
   c_reset: cover property (@(posedge sys_clk) device_reset_pulse);
   c_wake:  cover property (@(posedge sys_clk) state_r == EPRS_SLEEP ##1 state_r == EPRS_STANDBY);
endmodule // eprs_power_reset

// >>> dv/eprs_host_model.sv
// eprs_host_model.sv: spi host model driving select, serial clock and data
// assumes a 6 ns serial clock that runs only inside frames; gaps are given scaled in ns
`timescale 1ns/100ps
module eprs_host_model #(
   parameter int SLEEP_GAP_NS = 400,
   parameter int WAKE_GAP_NS  = 600
)(
   output logic spi_clk,
   output logic cs_n,
   output logic mosi
);
   logic [7:0] last_op;
   realtime    t_up;
   initial begin
      spi_clk = 1'b0;
      cs_n    = 1'b1;
      mosi    = 1'b0;
      last_op = 8'h00;
      t_up    = 0;
   end
   // nbits other than 8 is only used to provoke a refused frame
   task automatic send(input logic [7:0] op, input int nbits);
      realtime wait_ns;
      wait_ns = (last_op == 8'hb9) ? SLEEP_GAP_NS : (last_op == 8'hab) ? WAKE_GAP_NS : 0;
      if ($realtime - t_up < wait_ns) #(wait_ns - ($realtime - t_up));
      cs_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         mosi = op[7 - i];
         #3 spi_clk = 1'b1;
         #3 spi_clk = 1'b0;
      end
      cs_n    = 1'b1;
      mosi    = ~mosi; // released line must not keep a stale level
      last_op = op;
      t_up    = $realtime;
   endtask
endmodule // eprs_host_model

// >>> dv/eprs_power_reset_test.sv
// eprs_power_reset_test.sv: self-checking bench for the power/reset sequencer
// assumes shortened timing parameters; the host model supplies the spi frames
`timescale 1ns/100ps
module eprs_power_reset_test;
   import eprs_pkg::*;
   localparam int PU = 20, EN = 20, IR = 30, MR = 60, ER = 90;
   logic       sys_clk, rst, spi_clk, cs_n, mosi, modify_busy, chip_erase_busy;
   logic       write_in_progress_flag, deep_power_down, device_reset_pulse, cmd_accept_pulse;
   logic [7:0] accepted_opcode;
   logic [7:0] opc;
   eprs_regs_s delivery_regs;
   int         n_errors = 0, checks = 0, cyc = 0, t_acc, t_rst, t0;
   int         lim[3] = '{IR, MR, ER};
   int         lim_lo[3] = '{0, IR, MR};

   eprs_power_reset #(.POWERUP_CYC(PU), .ENTRY_CYC(EN), .IDLE_RST_CYC(IR),
      .MODIFY_RST_CYC(MR), .ERASE_RST_CYC(ER)) dut_u (
      .sys_clk(sys_clk), .rst(rst), .spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi),
      .modify_busy(modify_busy), .chip_erase_busy(chip_erase_busy),
      .write_in_progress_flag(write_in_progress_flag), .deep_power_down(deep_power_down),
      .device_reset_pulse(device_reset_pulse), .cmd_accept_pulse(cmd_accept_pulse),
      .accepted_opcode(accepted_opcode), .delivery_regs(delivery_regs));
   eprs_host_model #(.SLEEP_GAP_NS(EN * 20), .WAKE_GAP_NS(IR * 20)) host_u (
      .spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) cyc <= cyc + 1;

   task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // one frame, then watch maxc cycles for the accept and reset pulses
   task automatic run(input logic [7:0] op, input int nb, input int maxc);
      host_u.send(op, nb);
      t_acc = -1;
      t_rst = -1;
      repeat (maxc) begin
         @(posedge sys_clk);
         #1;
         if (cmd_accept_pulse === 1'b1 && t_acc < 0) begin
            t_acc = cyc;
            opc   = accepted_opcode;
         end
         if (device_reset_pulse === 1'b1 && t_rst < 0) t_rst = cyc;
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      #200000;
      n_errors++;
      $display("Error at %0t: watchdog expired", $time);
      tally_and_finish();
   end

   initial begin
      rst             = 1'b1;
      modify_busy     = 1'b0;
      chip_erase_busy = 1'b0;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      #1;
      t0 = cyc;
      check(write_in_progress_flag, 1, "busy at power-up");
      check(delivery_regs, {8'h00, 8'h00, 8'h20, 8'h01, 8'hff}, "delivery");
      run(8'h05, 8, 8);
      check(t_acc >= 0, 0, "accept in power-up");
      for (int i = 0; i < PU + 10 && write_in_progress_flag !== 1'b0; i++) begin
         @(posedge sys_clk);
         #1;
      end
      check(cyc - t0 >= PU - 1 && write_in_progress_flag === 1'b0, 1, "power-up length");
      $display("test power-up done");
      run(8'hb9, 7, 12);
      check({t_acc >= 0, deep_power_down}, 2'b00, "short entry frame");
      run(8'hb9, 8, EN);
      check({t_acc >= 0, opc, deep_power_down}, {1'b1, 8'hb9, 1'b1}, "sleep entry");
      run(8'h05, 8, 12);
      check({t_acc >= 0, deep_power_down}, 2'b01, "ignored in sleep");
      run(8'hab, 8, 12);
      check({t_acc >= 0, opc, deep_power_down}, {1'b1, 8'hab, 1'b0}, "wake");
      $display("test sleep done");
      run(8'h66, 8, 12);
      run(8'h05, 8, 12);
      run(8'h99, 8, IR + 20);
      check({t_rst >= 0, write_in_progress_flag}, 2'b00, "broken arm");
      // idle, modify and chip-erase recovery, each with a refused frame inside it
      for (int k = 0; k < 3; k++) begin
         @(posedge sys_clk);
         modify_busy     <= (k == 1);
         chip_erase_busy <= (k == 2);
         run(8'h66, 8, 12);
         run(8'h99, 8, 12);
         t0 = t_acc;
         check(write_in_progress_flag, 1, "busy in recovery");
         run(8'hb9, 8, lim[k] + 10);
         check({t_acc >= 0, t_rst > t0 + lim_lo[k], t_rst <= t0 + lim[k] + 2, deep_power_down},
               4'b0110, "reset recovery");
      end
      @(posedge sys_clk);
      modify_busy     <= 1'b0;
      chip_erase_busy <= 1'b0;
      $display("test reset done");
      tally_and_finish();
   end
endmodule // eprs_power_reset_test
